// *** src/rfoc_defines.svh ***
`ifndef RFOC_DEFINES_SVH
`define RFOC_DEFINES_SVH

`define RFOC_ADDR_CONTROL 32'h0000_0000
`define RFOC_ADDR_SOURCES 32'h0000_0004
`define RFOC_CONTROL_RESET 32'h0000_0000
`define RFOC_DIV_HI 30
`define RFOC_DIV_LO 16
`define RFOC_BIT_ON 15
`define RFOC_BIT_STOP_IN_IDLE 13
`define RFOC_BIT_OE 12
`define RFOC_BIT_RUN_IN_SLEEP 11
`define RFOC_BIT_SWITCH 9
`define RFOC_BIT_ACTIVE 8
`define RFOC_SEL_HI 3
`define RFOC_SEL_LO 0
`define RFOC_WRITE_MASK 32'h7fff_ba0f
`define RFOC_SEL_IGNORE_RUN_IN_SLEEP_A 4'h0
`define RFOC_SEL_IGNORE_RUN_IN_SLEEP_B 4'h1

`endif

// *** src/rfoc_pkg.sv ***
package rfoc_pkg;
  typedef struct packed {
    logic [14:0] divider;
    logic [3:0] source;
  } rfoc_setting_s;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [31:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } rfoc_wb_req_s;

  typedef enum logic [1:0] {
    RFOC_IDLE,
    RFOC_SWITCH
  } rfoc_state_e;
endpackage

// *** src/rfoc_top.sv ***
`timescale 1ns/10ps
`include "rfoc_defines.svh"

module rfoc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic [15:0] src_clk_i,
  input wire logic idle_mode_i,
  input wire logic sleep_mode_i,
  input wire logic clk_request_i,
  output logic ref_clock_out_pin_o,
  output logic ref_clock_out_pin_oe_o,
  output logic ref_clock_o
);
  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  rfoc_pkg::rfoc_setting_s live;
  rfoc_pkg::rfoc_setting_s next_live;
  rfoc_pkg::rfoc_state_e state;
  rfoc_pkg::rfoc_state_e next_state;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic ack;
  logic next_ack;
  logic err;
  logic next_err;
  logic [15:0] src_meta;
  logic [15:0] src_sync;
  logic [15:0] src_prev;
  logic [2:0] mode_meta;
  logic [2:0] mode_sync;
  logic [14:0] div_cnt;
  logic [14:0] next_div_cnt;
  logic clk_q;
  logic next_clk_q;
  logic pin_q;
  logic next_pin_q;
  logic pin_oe_q;
  logic next_pin_oe_q;
  rfoc_pkg::rfoc_wb_req_s req;

  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

  // Source clocks and power mode come from outside
  always_ff @(posedge clk_i) begin
    src_meta <= src_clk_i;
    src_sync <= src_meta;
    src_prev <= src_sync;
    mode_meta <= {clk_request_i, sleep_mode_i, idle_mode_i};
    mode_sync <= mode_meta;
  end

  logic enabled;
  logic halted;
  logic run_in_sleep_used;
  logic src_rise;
  logic strobe;
  logic [31:0] merged;
  logic sw_hold;

  always_comb begin
    enabled = ctrl[`RFOC_BIT_ON];
    run_in_sleep_used = live.source != `RFOC_SEL_IGNORE_RUN_IN_SLEEP_A && live.source != `RFOC_SEL_IGNORE_RUN_IN_SLEEP_B;
    halted = (mode_sync[0] && ctrl[`RFOC_BIT_STOP_IN_IDLE])
      || (mode_sync[1] && !(ctrl[`RFOC_BIT_RUN_IN_SLEEP] && run_in_sleep_used));
    src_rise = src_sync[live.source] && !src_prev[live.source];
    strobe = req.cyc && req.stb && !ack && !err;
    merged = lane_merge(ctrl, req.dat, req.sel);
  end

  // Register bus and control register
  always_comb begin
    next_ctrl = ctrl;
    next_live = live;
    next_state = state;
    next_ack = 1'b0;
    next_err = 1'b0;
    next_rdata = 32'h0000_0000;
    if (state == rfoc_pkg::RFOC_SWITCH) begin
      // Apply on a divider boundary so no runt pulse
      if (!enabled || div_cnt == 15'h0000) begin
        next_live.divider = ctrl[`RFOC_DIV_HI:`RFOC_DIV_LO];
        next_live.source = ctrl[`RFOC_SEL_HI:`RFOC_SEL_LO];
        next_ctrl[`RFOC_BIT_SWITCH] = 1'b0;
        next_state = rfoc_pkg::RFOC_IDLE;
      end
    end
    if (!enabled) begin
      next_live.divider = ctrl[`RFOC_DIV_HI:`RFOC_DIV_LO];
      next_live.source = ctrl[`RFOC_SEL_HI:`RFOC_SEL_LO];
    end
    next_ctrl[`RFOC_BIT_ACTIVE] = mode_sync[2] && enabled;
    // Switch bit after any hardware clear of this cycle
    sw_hold = next_ctrl[`RFOC_BIT_SWITCH];
    if (strobe) begin
      next_ack = 1'b1;
      case (req.adr)
        `RFOC_ADDR_CONTROL: begin
          next_rdata = ctrl;
          if (req.we) begin
            next_ctrl = (merged & `RFOC_WRITE_MASK) | (next_ctrl & ~`RFOC_WRITE_MASK);
            // Software can set the switch but not clear it
            next_ctrl[`RFOC_BIT_SWITCH] = (req.sel[1] && req.dat[`RFOC_BIT_SWITCH]) || sw_hold;
            next_ctrl[`RFOC_BIT_ACTIVE] = mode_sync[2] && enabled;
            if (req.sel[1] && req.dat[`RFOC_BIT_SWITCH]) begin
              next_state = rfoc_pkg::RFOC_SWITCH;
            end
          end
        end
        `RFOC_ADDR_SOURCES: begin
          next_rdata = {16'h0000, src_sync};
        end
        default: begin
          next_ack = 1'b0;
          next_err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `RFOC_CONTROL_RESET;
      live <= '0;
      state <= rfoc_pkg::RFOC_IDLE;
      ack <= 1'b0;
      err <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      live <= next_live;
      state <= next_state;
      ack <= next_ack;
      err <= next_err;
      rdata <= next_rdata;
    end
  end

  // Divider: zero passes source through, N toggles every N edges
  always_comb begin
    next_div_cnt = div_cnt;
    next_clk_q = clk_q;
    if (!enabled) begin
      next_div_cnt = 15'h0000;
      next_clk_q = 1'b0;
    end else if (!halted && live.divider == 15'h0000) begin
      next_clk_q = src_sync[live.source];
    end else if (!halted && src_rise) begin
      if (div_cnt + 15'h0001 >= live.divider) begin
        next_div_cnt = 15'h0000;
        next_clk_q = !clk_q;
      end else begin
        next_div_cnt = div_cnt + 15'h0001;
      end
    end
    next_pin_oe_q = enabled && ctrl[`RFOC_BIT_OE];
    next_pin_q = next_pin_oe_q && next_clk_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt <= 15'h0000;
      clk_q <= 1'b0;
      pin_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      clk_q <= next_clk_q;
      pin_q <= next_pin_q;
      pin_oe_q <= next_pin_oe_q;
    end
  end

  assign wb_dat_o = rdata;
  assign wb_ack_o = ack;
  assign wb_err_o = err;
  assign ref_clock_o = clk_q;
  assign ref_clock_out_pin_o = pin_q;
  assign ref_clock_out_pin_oe_o = pin_oe_q;
endmodule

// *** bench/rfoc_monitor.sv ***
`timescale 1ns/10ps
module rfoc_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic ref_clock_out_pin_oe_o,
  input wire logic ref_clock_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic rd_ctl, next_rd_ctl;
  always_comb next_rd_ctl = wb_stb_i && !wb_we_i && wb_adr_i == 32'h0;
  always_ff @(posedge clk_i) rd_ctl <= next_rd_ctl;
  a_req_answered: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o ^ wb_err_o)
    else $error("request not answered once");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_err_unmapped: assert property (wb_err_o |-> $past(wb_adr_i) != 32'h0 && $past(wb_adr_i) != 32'h4)
    else $error("error on mapped address");
  a_unused_zero: assert property (wb_ack_o && rd_ctl |-> (wb_dat_o & 32'h8000_44f0) == 32'h0)
    else $error("unused bits read nonzero");
  a_active_on: assert property (wb_ack_o && rd_ctl && wb_dat_o[8] |-> wb_dat_o[15])
    else $error("active while disabled");
  a_pin_enable: assert property (wb_ack_o && rd_ctl |-> ref_clock_out_pin_oe_o == (wb_dat_o[15] && wb_dat_o[12]))
    else $error("pin enable mismatch");
  a_off_low: assert property (wb_ack_o && rd_ctl && !wb_dat_o[15] |-> !ref_clock_o)
    else $error("clock high while disabled");
  a_off_stops: assert property (
    wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 32'h0 && wb_sel_i[1] && !wb_dat_i[15]
    ##1 wb_ack_o |-> ##[1:3] !ref_clock_o [*4]) else $error("clock runs after disable");
endmodule
bind rfoc_top rfoc_monitor i_rfoc_monitor (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .ref_clock_out_pin_oe_o(ref_clock_out_pin_oe_o), .ref_clock_o(ref_clock_o));

// *** bench/test_reference_clock_output_control.sv ***
`timescale 1ns/10ps
module test_reference_clock_output_control;
  typedef struct {logic [31:0] wv; logic idl, slp; int tg;} rfoc_row_s;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, idl = 0, slp = 0, req = 0, e, ack, err, pin, oe, rc;
  logic [31:0] adr = 0, dat = 0, q, dat_o;
  logic [15:0] src = 0;
  int miscompares = 0, samples_checked = 0, t;
  rfoc_row_s rows [8] = '{'{32'hffff_7fff, 0, 0, 0}, '{32'h0001_9002, 0, 0, 8}, '{32'h0001_b002, 1, 0, 0},
    '{32'h0001_9002, 1, 0, 8}, '{32'h0001_9002, 0, 1, 0}, '{32'h0001_9802, 0, 1, 8}, '{32'h0001_9801, 0, 1, 0},
    '{32'h0001_1002, 0, 0, 0}};
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) src <= src + 16'h1;
  rfoc_top i_rfoc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err), .src_clk_i(src),
    .idle_mode_i(idl), .sleep_mode_i(slp), .clk_request_i(req), .ref_clock_out_pin_o(pin),
    .ref_clock_out_pin_oe_o(oe), .ref_clock_o(rc));
  task chk(input logic [31:0] g, x);
    samples_checked++;
    if (g !== x) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task bus(input logic w, input logic [31:0] a, d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (!ack && !err && n < 20);
    q = dat_o;
    e = err;
    if (n >= 20) begin
      miscompares++;
      complete_run;
    end
    {cyc, stb} <= 2'b00;
  endtask
  task toggles(input int n, output int c);
    logic p;
    c = 0;
    p = rc;
    repeat (n) begin
      @(posedge clk_i);
      if (rc !== p) c++;
      p = rc;
    end
  endtask
  task complete_run;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #2000000;
    miscompares++;
    complete_run;
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    bus(0, 0, 0);
    chk(q, 32'h0);
    bus(0, 32'h8, 0);
    chk(e, 1);
    foreach (rows[i]) begin
      {idl, slp} <= {rows[i].idl, rows[i].slp};
      bus(1, 0, rows[i].wv & 32'hffff_7fff);
      bus(1, 0, rows[i].wv);
      bus(0, 0, 0);
      chk(q, rows[i].wv & 32'h7fff_b80f);
      chk(oe, rows[i].wv[15] & rows[i].wv[12]);
      chk(pin, rc & rows[i].wv[15] & rows[i].wv[12]);
      toggles(64, t);
      chk(t, rows[i].tg);
    end
    {idl, slp} <= 2'b00;
    bus(1, 0, 32'h0001_8002);
    bus(1, 0, 32'h0005_8002);
    toggles(64, t);
    chk(t, 8);
    bus(1, 0, 32'h0005_8202);
    repeat (8) bus(0, 0, 0);
    chk(q[9], 0);
    toggles(160, t);
    chk(t, 4);
    req <= 1;
    repeat (4) @(posedge clk_i);
    bus(0, 0, 0);
    chk(q[8], 1);
    rst_i <= 1;
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    bus(0, 0, 0);
    chk(q, 32'h0);
    chk(oe, 0);
    chk(rc, 0);
    complete_run;
  end
endmodule
